/* File: logic/fiber_regs_pkg.sv */
// Constants for the fiber control, page and error counter register logic
package fiber_regs_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [4:0] IDX_FIBER_CTRL = 5'h00;
   localparam logic [4:0] IDX_RX_ERR     = 5'h15;
   localparam logic [4:0] IDX_PAGE_SEL   = 5'h16;
   localparam logic [4:0] IDX_IRQ_SUM    = 5'h17;
   localparam int         ADDR_LSB       = 2;
   // Pages that own the paged registers
   localparam logic [7:0] PAGE_COPPER    = 8'h00;
   localparam logic [7:0] PAGE_FIBER     = 8'h01;
   // Fiber control bit positions
   localparam int B_RESET    = 15;
   localparam int B_LOOPBACK = 14;
   localparam int B_SPD_LSB  = 13;
   localparam int B_AN_EN    = 12;
   localparam int B_PWR_DN   = 11;
   localparam int B_RESTART  = 9;
   localparam int B_DUPLEX   = 8;
   localparam int B_SPD_MSB  = 6;
   localparam int B_IRQ      = 0;
   // Hardware reset values
   localparam logic       RST_SPD_LSB = 1'h0;
   localparam logic       RST_SPD_MSB = 1'h1;
   localparam logic       RST_DUPLEX  = 1'h1;
   localparam logic [7:0] RST_PAGE    = 8'h00;
   localparam logic [15:0] RST_RX_ERR = 16'h0000;
   localparam logic [15:0] RX_ERR_MAX = 16'hffff;
   // Fiber operating modes
   typedef enum logic [1:0] {
      MODE_100FX = 2'h0,
      MODE_1000X = 2'h1,
      MODE_AUTO  = 2'h2,
      MODE_SW    = 2'h3
   } fiber_mode_t;
   // Soft reset duration
   localparam int CLK_PERIOD_NS   = 40;
   localparam int SOFT_RST_NS     = 1000;
   localparam int SOFT_RST_CYCLES =
      (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Edges after reset until the enable loads from the second strap flop
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   // Soft reset sequencer; ST_IDLE and ST_RESTART codes differ in both bits
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_RESET   = 2'b01,
      ST_RESTART = 2'b11
   } seq_t;
endpackage

/* File: logic/phy_fiber_ctrl_page_regs.sv */
// Fiber control, page select, receive error and interrupt summary registers
//
// Function
// - Sixteen-bit read-only error counter saturates, never wraps
// - Count false carrier and symbol errors
// - Page select everywhere, low byte, retained on fiber reset
// - Interrupt summary bit zero, upper bits zero
// - Fiber reset bit acts now, self-clears
// - Fiber reset touches only fiber page state
// - Loopback returns transmit data, breaks the link
// - Loopback speed follows the fiber mode
// - Speed LSB depends on mode, writable mode 11
// - Speed MSB depends on mode, writable mode 11
// - Enable change breaks link, sets restart bit
// - Autoneg enable ignored in 100BASE-FX mode
// - Enable loads strap at hardware reset only
// - Leaving power down forces reset and restart
// - Restart self-clears; also restarts after resets
// - Duplex write applies only at later events
// - Isolate bit reads zero always
// - Collision test inert, bits five-zero zero
// - Mode 01 selects 1000BASE-X operation
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module phy_fiber_ctrl_page_regs
   import fiber_regs_pkg::*;
#(
   parameter int NUM_INT_SRC     = 8,
   parameter int SOFT_RST_CYCLES_P = SOFT_RST_CYCLES
) (
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   // Wishbone classic slave
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [6:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   // Strap pin and fiber mode
   input  wire logic                   autoneg_strap,
   input  wire logic [1:0]             fiber_mode,
   // Link state from the fiber datapath
   input  wire logic                   link_at_100,
   input  wire logic                   link_at_1000,
   // Copper receive error events, one-cycle pulses
   input  wire logic                   false_carrier,
   input  wire logic                   symbol_error,
   // Interrupt sources of this port
   input  wire logic [NUM_INT_SRC-1:0] int_status,
   input  wire logic [NUM_INT_SRC-1:0] int_enable,
   // Control towards the fiber logic
   output logic                        fiber_reset,
   output logic                        autoneg_restart,
   output logic                        autoneg_active,
   output logic                        loopback_en,
   output logic                        loopback_1000,
   output logic                        link_break,
   output logic                        power_down,
   output logic                        duplex_full
);

   ////////////////////////////////////////////////////////////////////////////
   // Parameter checks

   if (NUM_INT_SRC < 1) begin : g_bad_src
      $error("NUM_INT_SRC must be at least one");
   end
   if (SOFT_RST_CYCLES_P < 1 || SOFT_RST_CYCLES_P > 255) begin : g_bad_rst
      $error("SOFT_RST_CYCLES_P must lie in 1..255");
   end

   localparam logic [7:0] RST_LAST = 8'(SOFT_RST_CYCLES_P - 1);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic        ack;
      logic [15:0] dat;
      logic        strap_s1;
      logic        strap_s2;
      logic [1:0]  strap_cnt;
      logic        an_en;
      logic        spd_lsb;
      logic        spd_msb;
      logic        duplex;
      logic        duplex_act;
      logic        loopback;
      logic        pwr_dn;
      logic        restart;
      logic [7:0]  page;
      logic [15:0] rx_err;
      logic        irq;
      seq_t        seq;
      logic [7:0]  rst_cnt;
      logic        rst_pls;
      logic        an_pls;
      logic        an_act;
      logic        lb_1000;
      logic        brk;
   } state_t;

   state_t s_q;
   state_t s_d;

   // Saturating add so the counter pegs at its top
   function automatic logic [15:0] sat_add(input logic [15:0] v, input logic [1:0] n);
      logic [16:0] sum;
      sum = {1'b0, v} + {15'h0000, n};
      sat_add = sum[16] ? RX_ERR_MAX : sum[15:0];
   endfunction

   // Merge a write into a 16-bit value by byte lane
   function automatic logic [15:0] lane_mrg(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
      lane_mrg = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Read view of fiber control

   logic [15:0] ctrl_rd;
   logic        spd_lsb_rd;
   logic        spd_msb_rd;

   // Speed bits are fixed in 100FX and 1000X, follow the link in auto, stored in the software mode
   always_comb begin
      case (fiber_mode_t'(fiber_mode))
         MODE_100FX: begin
            spd_lsb_rd = 1'b1;
            spd_msb_rd = 1'b0;
         end
         MODE_1000X: begin
            spd_lsb_rd = 1'b0;
            spd_msb_rd = 1'b1;
         end
         MODE_AUTO: begin
            spd_lsb_rd = link_at_100;
            spd_msb_rd = link_at_1000;
         end
         default: begin
            spd_lsb_rd = s_q.spd_lsb;
            spd_msb_rd = s_q.spd_msb;
         end
      endcase
   end

   // Isolate, collision test and low bits stay zero
   always_comb begin
      ctrl_rd             = 16'h0000;
      ctrl_rd[B_RESET]    = (s_q.seq == ST_RESET);
      ctrl_rd[B_LOOPBACK] = s_q.loopback;
      ctrl_rd[B_SPD_LSB]  = spd_lsb_rd;
      ctrl_rd[B_AN_EN]    = s_q.an_en;
      ctrl_rd[B_PWR_DN]   = s_q.pwr_dn;
      ctrl_rd[B_RESTART]  = s_q.restart;
      ctrl_rd[B_DUPLEX]   = s_q.duplex;
      ctrl_rd[B_SPD_MSB]  = spd_msb_rd;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   logic [4:0]  idx;
   logic        req;
   logic        wr;
   logic        rd;
   logic        hit_ctrl;
   logic        hit_err;
   logic        hit_page;
   logic        hit_irq;
   logic [15:0] wdat;

   // Paged registers answer only on their own page
   always_comb begin
      idx      = wb_adr_i[ADDR_LSB +: 5];
      req      = wb_cyc_i && wb_stb_i && !s_q.ack;
      wr       = req && wb_we_i;
      rd       = req && !wb_we_i;
      hit_page = (idx == IDX_PAGE_SEL);
      hit_ctrl = (idx == IDX_FIBER_CTRL) && (s_q.page == PAGE_FIBER);
      hit_err  = (idx == IDX_RX_ERR) && (s_q.page == PAGE_COPPER);
      hit_irq  = (idx == IDX_IRQ_SUM) && (s_q.page == PAGE_COPPER);
      wdat     = lane_mrg(ctrl_rd, wb_dat_i, wb_sel_i);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic       ctrl_wr;
      logic       an_chg;
      logic       pd_exit;
      logic       go_reset;
      logic       go_restart;
      logic [1:0] n_err;
      ctrl_wr    = wr && hit_ctrl;
      an_chg     = 1'b0;
      pd_exit    = 1'b0;
      go_reset   = 1'b0;
      go_restart = 1'b0;
      n_err      = {1'b0, false_carrier} + {1'b0, symbol_error};
      s_d        = s_q;

      // Single-cycle ack; unmapped or off-page addresses read zero
      s_d.ack = req;
      if (rd) begin
         s_d.dat = hit_ctrl ? ctrl_rd :
                   hit_err  ? s_q.rx_err :
                   hit_page ? {8'h00, s_q.page} :
                   hit_irq  ? {15'h0000, s_q.irq} :
                              16'h0000;
      end

      // Strap settles through the synchroniser, then loads once
      s_d.strap_s1 = autoneg_strap;
      s_d.strap_s2 = s_q.strap_s1;
      if (s_q.strap_cnt != STRAP_SETTLE) begin
         s_d.strap_cnt = s_q.strap_cnt + 2'h1;
         if (s_q.strap_cnt == STRAP_SETTLE - 2'h1) begin
            s_d.an_en   = s_q.strap_s2;
            s_d.restart = 1'b1;
         end
      end

      // Page select keeps its value through fiber resets
      if (wr && hit_page && wb_sel_i[0]) begin
         s_d.page = wb_dat_i[7:0];
      end

      // Read clears the counter; a same-cycle error still counts
      if (rd && hit_err) begin
         s_d.rx_err = {14'h0000, n_err};
      end else begin
         s_d.rx_err = sat_add(s_q.rx_err, n_err);
      end

      // Summary refreshed every cycle
      s_d.irq = |(int_status & int_enable);

      // Control writes
      if (ctrl_wr) begin
         an_chg     = (wdat[B_AN_EN] != s_q.an_en);
         pd_exit    = s_q.pwr_dn && !wdat[B_PWR_DN];
         go_reset   = wdat[B_RESET] || pd_exit;
         go_restart = wdat[B_RESTART] || an_chg || pd_exit;
         s_d.loopback = wdat[B_LOOPBACK];
         s_d.an_en    = wdat[B_AN_EN];
         s_d.pwr_dn   = wdat[B_PWR_DN];
         s_d.duplex   = wdat[B_DUPLEX];
         if (fiber_mode == MODE_SW) begin
            s_d.spd_lsb = wdat[B_SPD_LSB];
            s_d.spd_msb = wdat[B_SPD_MSB];
         end
         if (go_restart) begin
            s_d.restart = 1'b1;
         end
      end

      // Soft reset and restart sequencer
      s_d.rst_pls = 1'b0;
      s_d.an_pls  = 1'b0;
      case (s_q.seq)
         ST_IDLE: begin
            if (go_reset) begin
               s_d.seq     = ST_RESET;
               s_d.rst_cnt = 8'h00;
            end else if (s_q.restart) begin
               s_d.seq = ST_RESTART;
            end
         end
         ST_RESET: begin
            // Only page 1 state is cleared; speed, enable, duplex kept
            s_d.rst_pls  = 1'b1;
            s_d.loopback = 1'b0;
            s_d.pwr_dn   = 1'b0;
            if (s_q.rst_cnt == RST_LAST) begin
               s_d.seq     = ST_RESTART;
               s_d.restart = 1'b1;
            end else begin
               s_d.rst_cnt = s_q.rst_cnt + 8'h01;
            end
         end
         ST_RESTART: begin
            // The stored duplex is applied here and nowhere else
            s_d.an_pls     = 1'b1;
            s_d.duplex_act = s_q.duplex;
            s_d.seq        = go_reset ? ST_RESET : ST_IDLE;
            s_d.rst_cnt    = 8'h00;
            if (!(ctrl_wr && go_restart)) begin
               s_d.restart = 1'b0;
            end
         end
         default: begin
            s_d.seq = ST_IDLE;
         end
      endcase

      // Derived control outputs
      s_d.an_act  = s_d.an_en && (fiber_mode != MODE_100FX);
      s_d.lb_1000 = (fiber_mode != MODE_100FX);
      s_d.brk     = s_d.loopback || an_chg || (s_d.seq != ST_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s_q            <= '0;
         s_q.seq        <= ST_IDLE;
         s_q.spd_lsb    <= RST_SPD_LSB;
         s_q.spd_msb    <= RST_SPD_MSB;
         s_q.duplex     <= RST_DUPLEX;
         s_q.duplex_act <= RST_DUPLEX;
         s_q.page       <= RST_PAGE;
         s_q.rx_err     <= RST_RX_ERR;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, each straight from a flip-flop

   assign wb_ack_o        = s_q.ack;
   assign wb_dat_o        = {16'h0000, s_q.dat};
   assign fiber_reset     = s_q.rst_pls;
   assign autoneg_restart = s_q.an_pls;
   assign autoneg_active  = s_q.an_act;
   assign loopback_en     = s_q.loopback;
   assign loopback_1000   = s_q.lb_1000;
   assign link_break      = s_q.brk;
   assign power_down      = s_q.pwr_dn;
   assign duplex_full     = s_q.duplex_act;

endmodule

/* File: tb/fiber_regs_sva.sv */
// Concurrent checks on the ports of the fiber register block
`timescale 1ns/1ps
module fiber_regs_sva
   import fiber_regs_pkg::*;
#(
   parameter int SOFT_RST_CYCLES_P = SOFT_RST_CYCLES
) (
   // Clock, reset and register bus
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [6:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Mode and fiber control
   input wire logic [1:0]  fiber_mode,
   input wire logic        fiber_reset,
   input wire logic        autoneg_restart,
   input wire logic        autoneg_active,
   input wire logic        loopback_en,
   input wire logic        loopback_1000,
   input wire logic        link_break,
   input wire logic        power_down,
   input wire logic        duplex_full
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////
   // Page mirror; run length of soft reset, as a repeat count would unroll badly
   logic       take;
   logic [7:0] page_q;
   logic [7:0] run_q;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         page_q <= 8'h00;
         run_q  <= 8'h00;
      end else begin
         if (take && wb_we_i && wb_adr_i == 7'h58)
            page_q <= wb_dat_i[7:0];
         run_q <= fiber_reset ? run_q + 8'h01 : 8'h00;
      end
   end
   // Bus answer and the reads that are checked
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   sequence s_page_rd;
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 7'h58;
   endsequence
   sequence s_ctrl_rd;
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 7'h00 && page_q == PAGE_FIBER;
   endsequence
   // Port relations
   a_ack_timing: assert property (take |=> s_ack_pulse)
      else $error("request without one ack pulse");
   a_page_view: assert property (s_page_rd |-> wb_dat_o[15:0] == {8'h00, page_q})
      else $error("page select read wrong");
   a_ctrl_fixed: assert property (s_ctrl_rd |-> (wb_dat_o[10:0] & 11'h4bf) == 11'h000)
      else $error("fixed control bits not zero");
   a_speed_mode: assert property (s_ctrl_rd |-> $past(fiber_mode) > 2'h1 ||
      {wb_dat_o[6], wb_dat_o[13]} == {$past(fiber_mode) == 2'h1, $past(fiber_mode) == 2'h0})
      else $error("speed bits wrong for mode");
   a_loop_speed: assert property (1'b1 |=> loopback_1000 == ($past(fiber_mode) != MODE_100FX))
      else $error("loopback speed wrong");
   a_an_mode: assert property (autoneg_active |-> $past(fiber_mode) != MODE_100FX)
      else $error("autoneg active in 100FX");
   a_loop_break: assert property (loopback_en && $past(loopback_en) |-> link_break)
      else $error("link kept in loopback");
   a_reset_len: assert property ($fell(fiber_reset) |-> run_q == 8'(SOFT_RST_CYCLES_P))
      else $error("soft reset length wrong");
   a_reset_restart: assert property ($fell(fiber_reset) |-> ##[0:2] autoneg_restart)
      else $error("no restart after soft reset");
   a_power_exit: assert property ($fell(power_down) |-> ##[0:3] fiber_reset)
      else $error("no reset on power down exit");
   a_duplex_apply: assert property ($changed(duplex_full) |-> autoneg_restart ||
      $past(autoneg_restart))
      else $error("duplex changed outside restart");
   a_restart_pulse: assert property (autoneg_restart |=> !autoneg_restart)
      else $error("restart pulse too long");
endmodule
bind phy_fiber_ctrl_page_regs fiber_regs_sva #(.SOFT_RST_CYCLES_P(SOFT_RST_CYCLES_P))
   fiber_regs_sva_inst (
   .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .fiber_mode(fiber_mode), .fiber_reset(fiber_reset),
   .autoneg_restart(autoneg_restart), .autoneg_active(autoneg_active),
   .loopback_en(loopback_en), .loopback_1000(loopback_1000), .link_break(link_break),
   .power_down(power_down), .duplex_full(duplex_full));

/* File: tb/sta_mgmt_model.sv */
// Station management controller model issuing classic Wishbone cycles
`timescale 1ns/1ps
module sta_mgmt_model (
   // Clock
   input  wire logic        sys_clk,
   // Bus towards the register block
   output logic             wb_cyc = 1'b0,
   output logic             wb_stb = 1'b0,
   output logic             wb_we  = 1'b0,
   output logic [6:0]       wb_adr = 7'h00,
   output logic [3:0]       wb_sel = 4'h0,
   output logic [31:0]      wb_dat = 32'h0,
   input  wire logic [31:0] wb_rdat,
   input  wire logic        wb_ack
);
   ////////////////////////////////////////////////////////////
   // One cycle; request held until ack is sampled, no fixed latency assumed
   task automatic xfer(input logic we, input logic [6:0] adr, input logic [31:0] wdat,
                       output logic [31:0] rdat);
      @(posedge sys_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= adr;
      wb_sel <= 4'h3;
      wb_dat <= wdat;
      do @(posedge sys_clk); while (wb_ack !== 1'b1);
      rdat = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_dat <= ~wdat; // Stale data must not look valid
   endtask
endmodule

/* File: tb/phy_fiber_ctrl_page_regs_test.sv */
// Self-checking bench for the fiber control, page and counter registers
`timescale 1ns/1ps
module phy_fiber_ctrl_page_regs_test import fiber_regs_pkg::*;;
   ////////////////////////////////////////////////////////////
   // Stimulus, observed outputs and tallies
   logic        sys_clk = 1'b0, resetn = 1'b0, autoneg_strap = 1'b1;
   logic [1:0]  fiber_mode = 2'h1;
   logic        link_at_100 = 1'b1, link_at_1000 = 1'b0;
   logic        false_carrier = 1'b0, symbol_error = 1'b0;
   logic [7:0]  int_status = 8'h00, int_enable = 8'h00;
   logic        wb_cyc, wb_stb, wb_we, wb_ack_o, fiber_reset, autoneg_restart;
   logic        autoneg_active, loopback_en, loopback_1000, link_break, power_down;
   logic        duplex_full;
   logic [6:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat, wb_dat_o;
   logic [15:0] spd_exp [4] = '{16'h3100, 16'h1140, 16'h3100, 16'h1140};
   int          mismatches = 0, total_checks = 0, cycles = 0, restarts = 0;
   phy_fiber_ctrl_page_regs #(.SOFT_RST_CYCLES_P(2)) phy_fiber_ctrl_page_regs_inst (
      .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .autoneg_strap(autoneg_strap),
      .fiber_mode(fiber_mode), .link_at_100(link_at_100), .link_at_1000(link_at_1000),
      .false_carrier(false_carrier), .symbol_error(symbol_error),
      .int_status(int_status), .int_enable(int_enable), .fiber_reset(fiber_reset),
      .autoneg_restart(autoneg_restart), .autoneg_active(autoneg_active),
      .loopback_en(loopback_en), .loopback_1000(loopback_1000), .link_break(link_break),
      .power_down(power_down), .duplex_full(duplex_full));
   sta_mgmt_model sta_mgmt_model_inst (
      .sys_clk(sys_clk), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
      .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat(wb_dat), .wb_rdat(wb_dat_o),
      .wb_ack(wb_ack_o));
   always #20 sys_clk = ~sys_clk;
   // Restart pulse tally and hang guard; the saturation run needs about 33000 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (autoneg_restart === 1'b1)
         restarts++;
      if (cycles == 60000) begin
         mismatches++;
         complete_run();
      end
   end
   // Comparisons, bus helpers and the verdict
   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic check_pin(input logic got, input logic exp);
      check_reg({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      logic [31:0] unused;
      sta_mgmt_model_inst.xfer(1'b1, a, d, unused);
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
      logic [31:0] d;
      sta_mgmt_model_inst.xfer(1'b0, a, 32'h0, d);
      check_reg(d, exp);
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Main sequence: page 0 registers first, then the fiber page
   initial begin
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (8) @(posedge sys_clk);
      check_reg(32'(restarts), 32'h1);
      rd_chk(7'h58, 32'h0);
      rd_chk(7'h00, 32'h0);
      rd_chk(7'h40, 32'h0);
      int_status <= 8'h24;
      int_enable <= 8'h04;
      rd_chk(7'h5c, 32'h1);
      int_enable <= 8'h08;
      rd_chk(7'h5c, 32'h0);
      rd_chk(7'h54, 32'h0);
      false_carrier <= 1'b1;
      symbol_error <= 1'b1;
      repeat (2) @(posedge sys_clk);
      symbol_error <= 1'b0;
      @(posedge sys_clk);
      false_carrier <= 1'b0;
      rd_chk(7'h54, 32'h5);
      rd_chk(7'h54, 32'h0);
      false_carrier <= 1'b1;
      symbol_error <= 1'b1;
      repeat (32768) @(posedge sys_clk);
      false_carrier <= 1'b0;
      symbol_error <= 1'b0;
      rd_chk(7'h54, 32'hffff);
      wr(7'h58, 32'hab01);
      rd_chk(7'h58, 32'h1);
      rd_chk(7'h54, 32'h0);
      // Speed bits in every mode
      for (int m = 0; m < 4; m++) begin
         fiber_mode <= m[1:0];
         rd_chk(7'h00, {16'h0, spd_exp[m]});
         check_pin(loopback_1000, m != 0);
      end
      wr(7'h00, 32'h1100);
      rd_chk(7'h00, 32'h1100);
      fiber_mode <= 2'h1;
      wr(7'h00, 32'h54bf);
      rd_chk(7'h00, 32'h5040);
      check_pin(link_break, 1'b1);
      check_pin(loopback_en, 1'b1);
      check_pin(duplex_full, 1'b1);
      wr(7'h00, 32'h9000);
      repeat (8) @(posedge sys_clk);
      rd_chk(7'h00, 32'h1040);
      rd_chk(7'h58, 32'h1);
      check_pin(duplex_full, 1'b0);
      check_pin(loopback_en, 1'b0);
      check_pin(link_break, 1'b0);
      check_reg(32'(restarts), 32'h2);
      wr(7'h00, 32'h1340);
      repeat (4) @(posedge sys_clk);
      rd_chk(7'h00, 32'h1140);
      check_pin(duplex_full, 1'b1);
      wr(7'h00, 32'h0140);
      repeat (4) @(posedge sys_clk);
      check_pin(autoneg_active, 1'b0);
      wr(7'h00, 32'h1140);
      repeat (4) @(posedge sys_clk);
      check_pin(autoneg_active, 1'b1);
      check_reg(32'(restarts), 32'h5);
      fiber_mode <= 2'h0;
      repeat (2) @(posedge sys_clk);
      check_pin(autoneg_active, 1'b0);
      fiber_mode <= 2'h1;
      wr(7'h00, 32'h1940);
      repeat (2) @(posedge sys_clk);
      check_pin(power_down, 1'b1);
      wr(7'h00, 32'h1140);
      repeat (8) @(posedge sys_clk);
      check_reg(32'(restarts), 32'h6);
      check_pin(power_down, 1'b0);
      // Hardware reset in mid run with the strap low: enable must follow it
      autoneg_strap <= 1'b0;
      resetn <= 1'b0;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (8) @(posedge sys_clk);
      check_reg(32'(restarts), 32'h7);
      check_pin(duplex_full, 1'b1);
      rd_chk(7'h58, 32'h0);
      wr(7'h58, 32'h0001);
      rd_chk(7'h00, 32'h0140);
      check_pin(autoneg_active, 1'b0);
      complete_run();
   end
endmodule
